// ==== design/fsq_pkg.sv ====
// constants and types for the flash command sequencer
package fsq_pkg;
    // apb word offsets of the control registers
    localparam logic [1:0] IDX_DIV  = 2'h0;
    localparam logic [1:0] IDX_PROT = 2'h1;
    localparam logic [1:0] IDX_STAT = 2'h2;
    localparam logic [1:0] IDX_CMD  = 2'h3;
    // array window: paddr[31:16] selects it
    localparam logic [15:0] ARR_HI  = 16'h0001;
    localparam logic [27:0] CTL_HI  = 28'h0000000;

    // field positions
    localparam int DV_LD     = 7;
    localparam int DV_PRE    = 6;
    localparam int ST_CBEF   = 7;
    localparam int ST_CCF    = 6;
    localparam int ST_ACCERR = 4;
    localparam int PR_DIS    = 0;

    // page geometry, 512-byte pages
    localparam int PAGE_LSB = 9;
    localparam logic [8:0] PAGE_ONES = 9'h1ff;

    // values after reset, and the last prescaler count
    localparam logic [5:0] DIV_RST  = 6'h00;
    localparam logic [7:0] PROT_RST = 8'hff;
    localparam logic [2:0] PRE_LAST = 3'h7;

    // command codes
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_BYTE  = 8'h20;
    localparam logic [7:0] CMD_BURST = 8'h25;
    localparam logic [7:0] CMD_PAGE  = 8'h40;
    localparam logic [7:0] CMD_MASS  = 8'h41;

    // operation lengths in flash clock pulses
    localparam int PULSE_BLANK = 4;
    localparam int PULSE_BYTE  = 9;
    localparam int PULSE_BURST = 4;
    localparam int PULSE_PAGE  = 4000;
    localparam int PULSE_MASS  = 20000;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ADDR = 2'b01,
        SEQ_CMD  = 2'b10
    } fsq_seq_t;
endpackage

// ==== design/fsq_fclk_div.sv ====
// flash clock enable divider
`timescale 1ns/100ps
module fsq_fclk_div (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // divider setting
    input  wire logic       en_i,
    input  wire logic       prescale_i,
    input  wire logic [5:0] div_i,
    // one-cycle flash clock pulse
    output logic            tick_o
);
    import fsq_pkg::*;

    typedef struct packed {
        logic [2:0] pre;
        logic [5:0] cnt;
        logic       tick;
    } fsq_div_st_t;

    fsq_div_st_t q;
    fsq_div_st_t d;

    // bus clock, optionally /8, then /(div+1)
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!en_i) begin
            d = '0;
        end else if (!prescale_i || q.pre == PRE_LAST) begin
            d.pre = 3'h0;
            if (q.cnt >= div_i) begin
                d.cnt  = 6'h00;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + 6'h01;
            end
        end else begin
            d.pre = q.pre + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;
endmodule

// ==== design/fsq_sequencer.sv ====
// flash command sequencer with apb register slave
// Operation
// - each command opens with one array write; address and data are latched
// - page erase acts on the whole 512-byte page of the address
// - erase and blank check ignore data; mass erase, blank check any address
// - command register takes only the five codes into the buffer
// - writing one to buffer-empty launches the buffered command
// - writing zero to buffer-empty mid sequence aborts and flags error
// - a command-complete flag reports the end of a command
// - access error clears only on write one; commands refused while set
// - array write before divider is written flags error
// - array write while buffer-empty is clear flags error
// - second array write before launch flags error
// - second command write before launch flags error
// - after array write, writing a non-command control register flags error
// - unknown command codes flag error
// - after command write, any control access but launch flags error
// - stop mode during program or erase aborts it and flags error
// - secured debug port may only blank check or mass erase
// - protection blocks program and erase from boundary up to top address
// - protection register loads from nonvolatile byte after reset
// - only the debug port may write the protection register
// - last unprotected address is boundary bits with ones below
// - divisor-loaded bit set by first divider write, enables commands
// - flash clock is bus clock, optional /8, over divisor plus one
`timescale 1ns/100ps
module fsq_sequencer #(
    parameter int unsigned P_BLANK = fsq_pkg::PULSE_BLANK,
    parameter int unsigned P_BYTE  = fsq_pkg::PULSE_BYTE,
    parameter int unsigned P_BURST = fsq_pkg::PULSE_BURST,
    parameter int unsigned P_PAGE  = fsq_pkg::PULSE_PAGE,
    parameter int unsigned P_MASS  = fsq_pkg::PULSE_MASS
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // system state
    input  wire logic        dbg_i,
    input  wire logic        secure_i,
    input  wire logic        stop_i,
    input  wire logic [7:0]  nv_prot_i,
    // flash array control
    output logic             arr_busy_o,
    output logic             arr_tick_o,
    output logic [7:0]       arr_cmd_o,
    output logic [15:0]      arr_addr_o,
    output logic [7:0]       arr_data_o
);
    import fsq_pkg::*;

    if (P_BLANK < 1 || P_BYTE < 1 || P_BURST < 1 ||
        P_PAGE < 1 || P_MASS < 1 || P_BLANK > 65535 ||
        P_BYTE > 65535 || P_BURST > 65535 ||
        P_PAGE > 65535 || P_MASS > 65535) begin : g_chk
        $error("fsq_sequencer: pulse counts must be 1..65535");
    end

    typedef struct packed {
        fsq_seq_t    seq;
        logic        loaded;
        logic        divisor_loaded_bit;
        logic        prescale_by_eight_bit;
        logic [5:0]  div;
        logic [7:0]  protection_reg;
        logic        cbef;
        logic        ccf;
        logic        accerr;
        logic [7:0]  cmd;
        logic [15:0] addr;
        logic [7:0]  data;
        logic        pend;
        logic        run;
        logic [7:0]  rcmd;
        logic [15:0] raddr;
        logic [7:0]  rdata;
        logic [15:0] cnt;
    } fsq_st_t;

    fsq_st_t q;
    fsq_st_t d;

    function automatic logic code_ok(input logic [7:0] c);
        return c == CMD_BLANK || c == CMD_BYTE || c == CMD_BURST ||
               c == CMD_PAGE || c == CMD_MASS;
    endfunction

    function automatic logic prog_erase(input logic [7:0] c);
        return c == CMD_BYTE || c == CMD_BURST ||
               c == CMD_PAGE || c == CMD_MASS;
    endfunction

    // last unprotected address from the boundary bits
    function automatic logic [15:0] last_free(input logic [7:0] p);
        return {p[7:1], PAGE_ONES};
    endfunction

    function automatic logic [15:0] pulses(input logic [7:0] c);
        unique case (c)
            CMD_BYTE:  pulses = 16'(P_BYTE);
            CMD_BURST: pulses = 16'(P_BURST);
            CMD_PAGE:  pulses = 16'(P_PAGE);
            CMD_MASS:  pulses = 16'(P_MASS);
            default:   pulses = 16'(P_BLANK);
        endcase
    endfunction

    // bus decode
    logic       acc;
    logic       is_arr;
    logic       is_ctl;
    logic [1:0] idx;
    logic       arr_wr;
    logic       ctl_acc;
    logic       ctl_wr;
    logic       div_wr;
    logic       prot_wr;
    logic       stat_wr;
    logic       cmd_wr;
    logic [7:0] pw;
    logic       tick;
    logic       blocked;
    logic       launch;
    logic       set_err;

    assign acc     = psel_i & penable_i;
    assign is_arr  = paddr_i[31:16] == ARR_HI;
    assign is_ctl  = paddr_i[31:4] == CTL_HI && paddr_i[1:0] == 2'h0;
    assign idx     = paddr_i[3:2];
    assign arr_wr  = acc & pwrite_i & is_arr;
    assign ctl_acc = acc & is_ctl;
    assign ctl_wr  = ctl_acc & pwrite_i;
    assign div_wr  = ctl_wr & (idx == IDX_DIV);
    assign prot_wr = ctl_wr & (idx == IDX_PROT);
    assign stat_wr = ctl_wr & (idx == IDX_STAT);
    assign cmd_wr  = ctl_wr & (idx == IDX_CMD);
    assign pw      = pwdata_i[7:0];

    // mass erase is refused whenever protection is enabled (PR_DIS bit clear), even if no region is protected
    assign blocked = !q.protection_reg[PR_DIS] &&
                     (q.cmd == CMD_MASS ||
                      q.addr > last_free(q.protection_reg));

    assign launch = stat_wr && pw[ST_CBEF] && q.seq == SEQ_CMD &&
                    !q.accerr && !(prog_erase(q.cmd) && blocked);

    fsq_fclk_div u_div (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .en_i       (q.divisor_loaded_bit),
        .prescale_i (q.prescale_by_eight_bit),
        .div_i      (q.div),
        .tick_o     (tick)
    );

    always_comb begin
        d = q;
        set_err = 1'b0;

        // one-shot copy of the nonvolatile byte after reset
        if (!q.loaded) begin
            d.loaded = 1'b1;
            d.protection_reg  = nv_prot_i;
        end

        // running operation; placed first so a launch this cycle wins
        if (q.run) begin
            if (stop_i && prog_erase(q.rcmd)) begin
                d.run  = 1'b0;
                d.pend = 1'b0;
                d.cbef = 1'b1;
                d.ccf  = 1'b1;
                set_err = 1'b1;
            end else if (tick) begin
                if (q.cnt == 16'h0001) begin
                    d.run = 1'b0;
                    d.ccf = !q.pend;
                end else begin
                    d.cnt = q.cnt - 16'h0001;
                end
            end
        end else if (q.pend) begin
            // buffer frees as soon as the array takes the command
            d.pend  = 1'b0;
            d.run   = 1'b1;
            d.cbef  = 1'b1;
            d.rcmd  = q.cmd;
            d.cnt   = pulses(q.cmd);
            d.raddr = q.addr;
            d.rdata = q.data;
            if (q.cmd == CMD_PAGE) begin
                d.raddr[PAGE_LSB-1:0] = '0;
            end
            if (q.cmd != CMD_BYTE && q.cmd != CMD_BURST) begin
                d.rdata = 8'h00;
            end
        end

        // array write opens a sequence
        if (arr_wr && !q.accerr) begin
            if (!q.divisor_loaded_bit) begin
                set_err = 1'b1;
            end else if (!q.cbef) begin
                set_err = 1'b1;
            end else if (q.seq != SEQ_IDLE) begin
                set_err = 1'b1;
            end else begin
                d.seq  = SEQ_ADDR;
                d.addr = paddr_i[15:0];
                d.data = pwdata_i[7:0];
            end
        end

        // divider is write once
        if (div_wr && !q.divisor_loaded_bit) begin
            d.divisor_loaded_bit  = 1'b1;
            d.prescale_by_eight_bit = pw[DV_PRE];
            d.div    = pw[5:0];
        end

        // application code cannot move the boundary
        if (prot_wr && dbg_i && q.seq == SEQ_IDLE) begin
            d.protection_reg = pw;
        end

        if (ctl_wr && q.seq == SEQ_ADDR && idx != IDX_CMD) begin
            set_err = 1'b1;
        end

        if (ctl_acc && q.seq == SEQ_CMD && !stat_wr) begin
            set_err = 1'b1;
        end

        if (cmd_wr && !q.accerr) begin
            if (q.seq != SEQ_ADDR) begin
                set_err = 1'b1;
            end else if (!code_ok(pw)) begin
                set_err = 1'b1;
            end else if (dbg_i && secure_i &&
                         pw != CMD_BLANK && pw != CMD_MASS) begin
                set_err = 1'b1;
            end else begin
                d.cmd = pw;
                d.seq = SEQ_CMD;
            end
        end

        if (stat_wr) begin
            if (pw[ST_ACCERR]) begin
                d.accerr = 1'b0;
            end
            if (q.seq != SEQ_IDLE && !pw[ST_CBEF]) begin
                set_err = 1'b1;
            end else if (q.seq == SEQ_CMD && pw[ST_CBEF] &&
                         !launch) begin
                set_err = 1'b1;
            end
        end

        if (launch) begin
            d.pend = 1'b1;
            d.cbef = 1'b0;
            d.ccf  = 1'b0;
            d.seq  = SEQ_IDLE;
        end

        // error set wins over a clear in the same cycle
        if (set_err) begin
            d.accerr = 1'b1;
            d.seq    = SEQ_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            q        <= '0;
            q.seq    <= SEQ_IDLE;
            q.div    <= DIV_RST;
            q.protection_reg  <= PROT_RST;
            q.cbef   <= 1'b1;
            q.ccf    <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // register read mux; zero wait states
    always_comb begin
        prdata_o = 32'h00000000;
        if (is_ctl) begin
            unique case (idx)
                IDX_DIV:  prdata_o[7:0] = {q.divisor_loaded_bit, q.prescale_by_eight_bit, q.div};
                IDX_PROT: prdata_o[7:0] = q.protection_reg;
                IDX_STAT: begin
                    prdata_o[ST_CBEF]   = q.cbef;
                    prdata_o[ST_CCF]    = q.ccf;
                    prdata_o[ST_ACCERR] = q.accerr;
                end
                IDX_CMD:  prdata_o[7:0] = q.cmd;
            endcase
        end
    end

    assign pready_o   = 1'b1;
    assign pslverr_o  = acc & !is_arr & !is_ctl;
    assign arr_busy_o = q.run;
    assign arr_tick_o = q.run & tick;
    assign arr_cmd_o  = q.rcmd;
    assign arr_addr_o = q.raddr;
    assign arr_data_o = q.rdata;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    early_write_a: assert property (
        arr_wr && !q.accerr && !q.divisor_loaded_bit |=> q.accerr && !q.divisor_loaded_bit)
        else $error("array write before divider not flagged");

    busy_buffer_a: assert property (
        arr_wr && !q.accerr && !q.cbef |=> q.accerr && q.seq == SEQ_IDLE)
        else $error("array write with full buffer not flagged");

    bad_code_a: assert property (
        cmd_wr && !code_ok(pw) |=> q.accerr)
        else $error("invalid command code accepted");

    abort_zero_a: assert property (
        stat_wr && !pw[ST_CBEF] && q.seq != SEQ_IDLE
        |=> q.accerr && q.seq == SEQ_IDLE)
        else $error("abort did not flag access error");

    launch_seq_a: assert property (
        launch && !q.run |=> !q.ccf && !q.cbef && q.pend
        ##1 q.run && q.cbef && !q.ccf)
        else $error("launch did not hand command to array");

    stop_abort_a: assert property (
        q.run && stop_i && prog_erase(q.rcmd) |=> !q.run && q.accerr)
        else $error("stop did not abort operation");

    // a command buffered before the error may still drain
    err_refuse_a: assert property (
        q.accerr && !(stat_wr && pw[ST_ACCERR])
        |=> q.accerr && !$rose(q.pend))
        else $error("access error cleared or command taken");

    prot_lock_a: assert property (
        q.loaded && prot_wr && !dbg_i |=> $stable(q.protection_reg))
        else $error("protection written by application");

    secure_cmd_a: assert property (
        cmd_wr && dbg_i && secure_i && pw == CMD_PAGE |=> q.accerr)
        else $error("secured debug erase accepted");

    done_flag_a: assert property (
        q.run && tick && q.cnt == 16'h0001 && !q.pend && !launch
        |=> q.ccf && !q.run)
        else $error("completion flag not set at end");
endmodule

// ==== tb/fsq_cpu_model.sv ====
// apb master standing in for the processor or the debug port
`timescale 1ns/100ps
module fsq_cpu_model (
    // clock
    input  wire logic        clk_i,
    // apb master side
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [31:0]      paddr_o,
    output logic [31:0]      pwdata_o,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i
);
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 32'h0;
        pwdata_o  = 32'h0;
    end
    // called right after a rising edge; ok stays low if pready never came
    task automatic xfer(input logic we, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic ok);
        ok = 1'b0;
        rd = 32'h0;
        psel_o   <= 1'b1;
        pwrite_o <= we;
        paddr_o  <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge clk_i);
            if (pready_i === 1'b1) begin
                ok = 1'b1;
                rd = prdata_i;
            end
        end
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        // released data no longer shows the last value
        pwdata_o  <= ~d;
        // idle edge so the next request never lands in this time step
        @(posedge clk_i);
    endtask
endmodule

// ==== tb/flash_command_sequencer_tb.sv ====
// self-checking bench for the flash command sequencer
`timescale 1ns/100ps
module flash_command_sequencer_tb;
    import fsq_pkg::*;
    typedef struct {logic [32:0] v; logic [32:0] m;} fsq_rexp_t;
    typedef struct {logic [31:0] v; logic [31:0] m; int n;} fsq_aexp_t;
    localparam logic [31:0] A_DIV  = {28'h0, IDX_DIV, 2'h0};
    localparam logic [31:0] A_PROT = {28'h0, IDX_PROT, 2'h0};
    localparam logic [31:0] A_ST   = {28'h0, IDX_STAT, 2'h0};
    localparam logic [31:0] A_CMD  = {28'h0, IDX_CMD, 2'h0};
    localparam logic [32:0] M_ALL  = 33'h1_ffff_ffff;
    logic        clk_i, rst_b_i, dbg, sec, stop, ok, bprev;
    logic [7:0]  nv, c;
    logic [31:0] paddr, pwdata, prdata, rdv;
    logic        psel, penable, pwrite, pready, pslverr;
    logic        busy, tick;
    logic [7:0]  acmd, adata;
    logic [15:0] aaddr;
    logic [7:0]  codes [5] = '{CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_PAGE,
                               CMD_MASS};
    int          error_cnt, comparisons, cyc, last_t, ticks, per;
    fsq_rexp_t   rq [$];
    fsq_aexp_t   aq [$];
    fsq_rexp_t   re;
    fsq_aexp_t   ae;

    fsq_cpu_model u_cpu (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
        .prdata_i(prdata), .pready_i(pready));
    // short pulse counts; mass erase must outlast a full command sequence
    fsq_sequencer #(.P_BLANK(2), .P_BYTE(3), .P_BURST(2), .P_PAGE(4),
        .P_MASS(16)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .dbg_i(dbg), .secure_i(sec), .stop_i(stop),
        .nv_prot_i(nv), .arr_busy_o(busy), .arr_tick_o(tick),
        .arr_cmd_o(acmd), .arr_addr_o(aaddr), .arr_data_o(adata));

    always #12.5 clk_i = ~clk_i;

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        u_cpu.xfer(1'b1, a, d, rdv, ok);
        if (!ok) begin
            error_cnt++;
            finish_test();
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [32:0] v,
                      input logic [32:0] m);
        rq.push_back('{v, m});
        u_cpu.xfer(1'b0, a, 32'h0, rdv, ok);
        if (!ok) begin
            error_cnt++;
            finish_test();
        end
    endtask
    // array write, command write, launch; expectation noted when asked
    task automatic seq(input logic [15:0] a, input logic [7:0] d,
                       input logic [7:0] k, input logic note, input int n);
        logic pg;
        logic dat;
        pg  = (k == CMD_PAGE);
        dat = (k == CMD_BYTE || k == CMD_BURST);
        if (note) aq.push_back('{{k, pg ? {a[15:9], 9'h0} : a,
            dat ? d : 8'h0}, (pg || dat) ? 32'hffffffff : 32'hff0000ff, n});
        wr({ARR_HI, a}, {24'h0, d});
        wr(A_CMD, {24'h0, k});
        wr(A_ST, 32'h80);
    endtask
    task automatic err_chk(input logic b);
        rd(A_ST, {28'h0, b, 4'h0}, 33'h1_0000_0010);
        if (b) wr(A_ST, 32'h10);
    endtask
    task automatic wait_idle();
        int q;
        q = 0;
        for (int i = 0; i < 600 && q < 6; i++) begin
            @(posedge clk_i);
            q = (busy === 1'b0) ? q + 1 : 0;
        end
        if (q < 6) begin
            error_cnt++;
            finish_test();
        end
    endtask
    function automatic int pulses(input logic [7:0] k);
        case (k)
            CMD_BLANK: return 2;
            CMD_BYTE:  return 3;
            CMD_BURST: return 2;
            CMD_PAGE:  return 4;
            default:   return 16;
        endcase
    endfunction

    // result monitor: oldest note against what appears
    always @(posedge clk_i) begin
        cyc++;
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (rq.size() == 0) check(40'h1, 40'h0);
            else begin
                re = rq.pop_front();
                check({pslverr, prdata} & re.m, re.v & re.m);
            end
        end
        if (busy === 1'b1 && bprev !== 1'b1) begin
            ticks  = 0;
            last_t = 0;
            if (aq.size() == 0) check(40'h1, 40'h0);
            else begin
                ae = aq.pop_front();
                check({acmd, aaddr, adata} & ae.m, ae.v & ae.m);
            end
        end
        if (tick === 1'b1) begin
            ticks++;
            if (last_t != 0) check(40'(cyc - last_t), 40'(per));
            last_t = cyc;
        end
        if (busy === 1'b0 && bprev === 1'b1 && ae.n != 0)
            check(40'(ticks), 40'(ae.n));
        bprev = busy;
    end

    initial begin
        clk_i = 1'b0;
        rst_b_i = 1'b0;
        {dbg, sec, stop} = 3'b000;
        void'($urandom(52));
        nv = {8'($urandom()) | 8'h01};
        per = 1 + ($urandom() % 4);
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rd(A_ST, {1'b0, 32'hc0}, M_ALL);
        rd(A_DIV, 33'h0, M_ALL);
        rd(A_PROT, {25'h0, nv}, M_ALL);
        rd(32'h10, 33'h1_0000_0000, 33'h1_0000_0000);
        rd({ARR_HI, 16'h0100}, 33'h0, M_ALL);
        wr({ARR_HI, 16'h0100}, 32'h55);
        err_chk(1'b1);
        err_chk(1'b0);
        wr(A_DIV, 32'(per - 1));
        rd(A_DIV, {25'h0, 8'(per + 32'h7f)}, M_ALL);
        wr(A_DIV, 32'h3f);
        rd(A_DIV, {25'h0, 8'(per + 32'h7f)}, M_ALL);
        // distinct addresses: no byte programmed twice per erase
        for (int k = 0; k < 5; k++) begin
            seq(16'h1000 + 16'(k * 512) + 16'($urandom() % 512),
                8'($urandom()), codes[k], 1'b1, pulses(codes[k]));
            wait_idle();
            rd(A_ST, {1'b0, 32'hc0}, M_ALL);
        end
        for (int k = 1; k < 7; k++) begin
            wr({ARR_HI, 16'h2000 + 16'(k)}, 32'h0);
            case (k)
                1: wr({ARR_HI, 16'h2100}, 32'h0);
                2: repeat (2) wr(A_CMD, {24'h0, CMD_BYTE});
                3: wr(A_DIV, 32'h01);
                4: begin
                    do c = 8'($urandom());
                    while (c inside {CMD_BLANK, CMD_BYTE, CMD_BURST,
                                     CMD_PAGE, CMD_MASS});
                    wr(A_CMD, {24'h0, c});
                end
                5: begin
                    wr(A_CMD, {24'h0, CMD_BLANK});
                    rd(A_CMD, {25'h0, CMD_BLANK}, M_ALL);
                end
                default: begin
                    wr(A_ST, 32'h00);
                    seq(16'h2200, 8'h11, CMD_BYTE, 1'b0, 0);
                    wait_idle();
                end
            endcase
            err_chk(1'b1);
        end
        // secured debug port: program and page erase refused, blank check runs
        dbg <= 1'b1;
        sec <= 1'b1;
        for (int k = 1; k < 4; k++) begin
            seq(16'h2300, 8'h0, codes[k], 1'b0, 0);
            err_chk(1'b1);
        end
        seq(16'h2300, 8'h0, CMD_BLANK, 1'b1, 2);
        wait_idle();
        err_chk(1'b0);
        sec <= 1'b0;
        wr(A_PROT, 32'hde);
        dbg <= 1'b0;
        wr(A_PROT, 32'hff);
        rd(A_PROT, 33'hde, M_ALL);
        seq(16'he000, 8'h33, CMD_BYTE, 1'b0, 0);
        err_chk(1'b1);
        seq(16'hdfff, 8'h33, CMD_BYTE, 1'b1, 3);
        wait_idle();
        err_chk(1'b0);
        seq(16'h0000, 8'h0, CMD_MASS, 1'b0, 0);
        err_chk(1'b1);
        dbg <= 1'b1;
        wr(A_PROT, 32'hff);
        dbg <= 1'b0;
        // launch while running stays buffered; array write then refused
        seq(16'h3000, 8'h0, CMD_MASS, 1'b1, 16);
        seq(16'h3400, 8'h66, CMD_BYTE, 1'b1, 3);
        wr({ARR_HI, 16'h3500}, 32'h0);
        wait_idle();
        err_chk(1'b1);
        seq(16'h3800, 8'h0, CMD_PAGE, 1'b1, 0);
        for (int i = 0; i < 50 && busy !== 1'b1; i++) @(posedge clk_i);
        stop <= 1'b1;
        wait_idle();
        stop <= 1'b0;
        err_chk(1'b1);
        check(40'(aq.size() + rq.size()), 40'h0);
        finish_test();
    end
endmodule
